// file: sctrp_pkg.sv
// constants and carrier types of the set/clear/toggle register pair
// assumes one synchronous clock domain shared with the accessing logic
package sctrp_pkg;

   localparam int unsigned SCTRP_DATA_W = 8;

   // default bit map: [7:6] reserved, [5] write-only, [4] read-only,
   // [3:0] read/write
   localparam logic [SCTRP_DATA_W-1:0] SCTRP_RW_MASK  = 8'h0F;
   localparam logic [SCTRP_DATA_W-1:0] SCTRP_RO_MASK  = 8'h10;
   localparam logic [SCTRP_DATA_W-1:0] SCTRP_WO_MASK  = 8'h20;
   localparam logic [SCTRP_DATA_W-1:0] SCTRP_RST_VAL  = 8'h00;
   localparam logic [SCTRP_DATA_W-1:0] SCTRP_ZERO     = 8'h00;
   localparam logic                    SCTRP_KEEP_DBG = 1'h0;

   typedef enum logic [1:0]
   {
      SCTRP_SEL_BASE              = 2'h0,
      SCTRP_SEL_OUTPUT_BIT_SET    = 2'h1,
      SCTRP_SEL_BIT_TOGGLE_ALIAS  = 2'h3,
      SCTRP_SEL_BIT_CLEAR_ALIAS   = 2'h2
   } sctrp_sel_t;

   typedef struct packed
   {
      logic                    valid;
      logic                    write;
      sctrp_sel_t              sel;
      logic [SCTRP_DATA_W-1:0] wdata;
   } sctrp_access_t;

endpackage

// file: sctrp_reg_pair.sv
// base register with set, clear and toggle aliases on one access port
// assumes access, roValue and softRst come from logic on clk
//
// Summary of operation
// - read/write bits read back what was stored and take written data.
// - read-only bits read the live hardware value and ignore writes.
// - write-only bits take writes and read as zero.
// - reserved bits always read as zero whatever was written.
// - reset loads the reset value; peripheral soft reset does too, except debug.
// - base and every alias read back the same base value.
// - a one written to the clear alias clears that base bit.
// - a one written to the set alias sets that base bit.
// - a one written to the toggle alias inverts that base bit.
// - alias writes act on the base directly, with no read-modify-write.
`timescale 1ns/1ps

module sctrp_reg_pair
   import sctrp_pkg::*;
#(
   parameter logic [SCTRP_DATA_W-1:0] RW_MASK    = SCTRP_RW_MASK,
   parameter logic [SCTRP_DATA_W-1:0] RO_MASK    = SCTRP_RO_MASK,
   parameter logic [SCTRP_DATA_W-1:0] WO_MASK    = SCTRP_WO_MASK,
   parameter logic [SCTRP_DATA_W-1:0] RESET_VAL  = SCTRP_RST_VAL,
   parameter logic                    KEEP_DEBUG = SCTRP_KEEP_DBG
)
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    softRst,
   input  wire sctrp_access_t           access,
   input  wire logic [SCTRP_DATA_W-1:0] roValue,
   output logic      [SCTRP_DATA_W-1:0] rdData_reg,
   output logic                         rdValid_reg,
   output logic      [SCTRP_DATA_W-1:0] value_reg
);

   localparam logic [SCTRP_DATA_W-1:0] WR_MASK   = RW_MASK | WO_MASK;
   localparam logic [SCTRP_DATA_W-1:0] RSVD_MASK =
      ~(RW_MASK | RO_MASK | WO_MASK);

   generate
      if (((RW_MASK & RO_MASK) | (RW_MASK & WO_MASK) | (RO_MASK & WO_MASK))
          != SCTRP_ZERO)
      begin : g_bad_masks
         $error("bit access masks overlap");
      end
   endgenerate

   // only writable positions ever reach the store
   function automatic logic [SCTRP_DATA_W-1:0] wrBits
   (
      input logic [SCTRP_DATA_W-1:0] d
   );
      wrBits = d & WR_MASK;
   endfunction

   logic [SCTRP_DATA_W-1:0] store_reg;
   logic [SCTRP_DATA_W-1:0] store_next;
   logic [SCTRP_DATA_W-1:0] rdData_next;
   logic                    rdValid_next;
   logic                    doWrite;
   logic                    doRead;
   logic [SCTRP_DATA_W-1:0] setMask;
   logic [SCTRP_DATA_W-1:0] clrMask;
   logic [SCTRP_DATA_W-1:0] tglMask;
   logic [SCTRP_DATA_W-1:0] baseMask;
   logic [SCTRP_DATA_W-1:0] applied;

   assign doWrite = access.valid && access.write;
   assign doRead  = access.valid && !access.write;

   // decode one access into per-bit action masks
   always_comb
   begin
      setMask  = SCTRP_ZERO;
      clrMask  = SCTRP_ZERO;
      tglMask  = SCTRP_ZERO;
      baseMask = SCTRP_ZERO;
      if (doWrite)
      begin
         unique case (access.sel)
            SCTRP_SEL_BASE:             baseMask = WR_MASK;
            SCTRP_SEL_OUTPUT_BIT_SET:   setMask  = wrBits(access.wdata);
            SCTRP_SEL_BIT_TOGGLE_ALIAS: tglMask  = wrBits(access.wdata);
            SCTRP_SEL_BIT_CLEAR_ALIAS:  clrMask  = wrBits(access.wdata);
         endcase
      end
   end

   genvar b;
   generate
      for (b = 0; b < SCTRP_DATA_W; b++)
      begin : g_bit
         always_comb
         begin
            if (baseMask[b])
               applied[b] = access.wdata[b];
            else if (setMask[b])
               applied[b] = 1'h1;
            else if (clrMask[b])
               applied[b] = 1'h0;
            else if (tglMask[b])
               applied[b] = ~store_reg[b];
            else
               applied[b] = store_reg[b];
         end
      end
   endgenerate

   always_comb
   begin
      store_next = applied & WR_MASK;
      if (softRst && !KEEP_DEBUG)
         store_next = RESET_VAL & WR_MASK;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         store_reg <= RESET_VAL & WR_MASK;
      else
         store_reg <= store_next;
   end

   // read path: same answer for base and every alias
   always_comb
   begin
      rdValid_next = doRead;
      rdData_next  = rdData_reg;
      if (doRead)
      begin
         // select does not matter on read
         // write-only returns zero, not to be relied on
         rdData_next = (store_reg & RW_MASK) | (roValue & RO_MASK);
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdData_reg  <= SCTRP_ZERO;
         rdValid_reg <= 1'h0;
         value_reg   <= SCTRP_ZERO;
      end
      else
      begin
         rdData_reg  <= rdData_next;
         rdValid_reg <= rdValid_next;
         // hardware sees stored bits one cycle after the store updates
         value_reg   <= store_reg;
      end
   end

   chk_rw_write_store: assert property (@(posedge clk) disable iff (rst)
      (doWrite && access.sel == SCTRP_SEL_BASE && !softRst)
      |=> ((store_reg & RW_MASK) == ($past(access.wdata) & RW_MASK)))
      else $error("base write not stored");

   chk_ro_no_store: assert property (@(posedge clk) disable iff (rst)
      (store_reg & ~WR_MASK) == SCTRP_ZERO)
      else $error("read-only or reserved bit stored");

   chk_ro_read_live: assert property (@(posedge clk) disable iff (rst)
      doRead |=> ((rdData_reg & RO_MASK) == ($past(roValue) & RO_MASK)))
      else $error("read-only bit not live on read");

   chk_wo_read_zero: assert property (@(posedge clk) disable iff (rst)
      rdValid_reg |-> ((rdData_reg & WO_MASK) == SCTRP_ZERO))
      else $error("write-only bit leaked on read");

   chk_rsvd_read_zero: assert property (@(posedge clk) disable iff (rst)
      (rdData_reg & RSVD_MASK) == SCTRP_ZERO)
      else $error("reserved bit read nonzero");

   chk_reset_load: assert property (@(posedge clk)
      (rst || (softRst && !KEEP_DEBUG))
      |=> (store_reg == (RESET_VAL & WR_MASK)))
      else $error("reset value not loaded");

   chk_pair_read_same: assert property (@(posedge clk) disable iff (rst)
      doRead
      |=> ((rdData_reg & RW_MASK) == ($past(store_reg) & RW_MASK)))
      else $error("read differs from base value");

   chk_clear_alias: assert property (@(posedge clk) disable iff (rst)
      (doWrite && access.sel == SCTRP_SEL_BIT_CLEAR_ALIAS && !softRst)
      |=> (store_reg == ($past(store_reg) & ~wrBits($past(access.wdata)))))
      else $error("clear alias wrong");

   chk_set_alias: assert property (@(posedge clk) disable iff (rst)
      (doWrite && access.sel == SCTRP_SEL_OUTPUT_BIT_SET && !softRst)
      |=> (store_reg == ($past(store_reg) | wrBits($past(access.wdata)))))
      else $error("set alias wrong");

   chk_toggle_alias: assert property (@(posedge clk) disable iff (rst)
      (doWrite && access.sel == SCTRP_SEL_BIT_TOGGLE_ALIAS && !softRst)
      |=> (store_reg == ($past(store_reg) ^ wrBits($past(access.wdata)))))
      else $error("toggle alias wrong");

   chk_alias_to_out: assert property (@(posedge clk) disable iff (rst)
      (doWrite && access.sel != SCTRP_SEL_BASE && !softRst)
      |=> ##1 (value_reg == $past(store_reg)))
      else $error("alias result not on output");

   chk_zero_hold: assert property (@(posedge clk) disable iff (rst)
      (doWrite && access.sel != SCTRP_SEL_BASE && !softRst)
      |=> ((store_reg & ~$past(access.wdata))
           == ($past(store_reg) & ~$past(access.wdata))))
      else $error("zero alias bit changed base");

   // side checks on the read port: a read is a one-cycle answer and the
   // held data must not drift between reads, or software would see a
   // value that no access produced
   chk_rdvalid_set: assert property (@(posedge clk) disable iff (rst)
      doRead |=> rdValid_reg)
      else $error("read not answered");

   chk_rdvalid_idle: assert property (@(posedge clk) disable iff (rst)
      !doRead |=> !rdValid_reg)
      else $error("read valid without a read");

   chk_rddata_hold: assert property (@(posedge clk) disable iff (rst)
      !doRead |=> $stable(rdData_reg))
      else $error("read data changed without a read");

   chk_read_no_change: assert property (@(posedge clk) disable iff (rst)
      (doRead && !softRst) |=> $stable(store_reg))
      else $error("read altered the base value");

   // store side: nothing moves without a write, and a soft reset on a
   // debug register must leave it alone
   chk_idle_hold: assert property (@(posedge clk) disable iff (rst)
      (!access.valid && !softRst) |=> $stable(store_reg))
      else $error("base changed with no access");

   chk_value_follow: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> (value_reg == $past(store_reg)))
      else $error("output does not follow base");

   chk_value_masked: assert property (@(posedge clk) disable iff (rst)
      (value_reg & ~WR_MASK) == SCTRP_ZERO)
      else $error("unwritable bit on output");

   chk_wo_write_store: assert property (@(posedge clk) disable iff (rst)
      (doWrite && access.sel == SCTRP_SEL_BASE && !softRst)
      |=> ((store_reg & WO_MASK) == ($past(access.wdata) & WO_MASK)))
      else $error("write-only bit not stored");

   chk_soft_keep: assert property (@(posedge clk) disable iff (rst)
      (softRst && KEEP_DEBUG && !doWrite) |=> $stable(store_reg))
      else $error("debug register lost its value");

   chk_soft_beats_write: assert property (@(posedge clk) disable iff (rst)
      (softRst && !KEEP_DEBUG && doWrite)
      |=> (store_reg == (RESET_VAL & WR_MASK)))
      else $error("write won over soft reset");

   chk_reset_outputs: assert property (@(posedge clk)
      rst |=> (!rdValid_reg && value_reg == SCTRP_ZERO))
      else $error("outputs not cleared by reset");

   chk_set_no_clear: assert property (@(posedge clk) disable iff (rst)
      (doWrite && access.sel == SCTRP_SEL_OUTPUT_BIT_SET && !softRst)
      |=> (($past(store_reg) & ~store_reg) == SCTRP_ZERO))
      else $error("set alias cleared a bit");

   chk_clear_no_set: assert property (@(posedge clk) disable iff (rst)
      (doWrite && access.sel == SCTRP_SEL_BIT_CLEAR_ALIAS && !softRst)
      |=> ((store_reg & ~$past(store_reg)) == SCTRP_ZERO))
      else $error("clear alias set a bit");

   chk_tgl_only_ones: assert property (@(posedge clk) disable iff (rst)
      (doWrite && access.sel == SCTRP_SEL_BIT_TOGGLE_ALIAS && !softRst)
      |=> (((store_reg ^ $past(store_reg)) & ~$past(access.wdata))
           == SCTRP_ZERO))
      else $error("toggle alias flipped a zero bit");

endmodule

// file: tb_top.sv
// self-checking bench for the set/clear/toggle register pair
// assumes the design checks its own timing with embedded assertions
`timescale 1ns/1ps

module tb_top
   import sctrp_pkg::*;
;
   localparam logic [7:0] WM = SCTRP_RW_MASK | SCTRP_WO_MASK;

   logic          clk = 1'b0;
   logic          rst = 1'b1;
   logic          softRst = 1'b0;
   sctrp_access_t access = '0;
   logic [7:0]    roValue = 8'h00;
   logic [7:0]    rdData;
   logic          rdValid;
   logic [7:0]    value;
   logic [7:0]    valueDbg;
   logic [7:0]    model = 8'h00;
   int            badCount = 0;
   int            totalChecks = 0;

   sctrp_reg_pair i_dut
   (
      .clk         (clk),
      .rst         (rst),
      .softRst     (softRst),
      .access      (access),
      .roValue     (roValue),
      .rdData_reg  (rdData),
      .rdValid_reg (rdValid),
      .value_reg   (value)
   );

   // debug flavour: same stimulus, must survive a soft reset
   sctrp_reg_pair
   #(
      .KEEP_DEBUG (1'b1)
   )
   i_dut_dbg
   (
      .clk         (clk),
      .rst         (rst),
      .softRst     (softRst),
      .access      (access),
      .roValue     (roValue),
      .rdData_reg  (),
      .rdValid_reg (),
      .value_reg   (valueDbg)
   );

   initial
   begin
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         badCount++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic w, input sctrp_sel_t s, input logic [7:0] d);
      access = '{1'b1, w, s, d};
      @(posedge clk);
      #1;
      access = '0;
   endtask

   // write through any register, keep the bench model of the store
   task automatic wr(input sctrp_sel_t s, input logic [7:0] d);
      acc(1'b1, s, d);
      case (s)
         SCTRP_SEL_BASE:             model = d & WM;
         SCTRP_SEL_OUTPUT_BIT_SET:   model = model | (d & WM);
         SCTRP_SEL_BIT_CLEAR_ALIAS:  model = model & ~d;
         default:                    model = model ^ (d & WM);
      endcase
      @(posedge clk);
      #1;
      check(value & WM, model);
   endtask

   // write-only bits expected as zero, reserved bits always zero
   task automatic rd(input sctrp_sel_t s);
      acc(1'b0, s, 8'h00);
      check({7'h00, rdValid}, 8'h01);
      check(rdData, (model & SCTRP_RW_MASK) | (roValue & SCTRP_RO_MASK));
   endtask

   task automatic t_reset();
      rd(SCTRP_SEL_BASE);
      check(value, SCTRP_RST_VAL & WM);
   endtask

   task automatic t_access();
      roValue = 8'h10;
      wr(SCTRP_SEL_BASE, 8'h3F);
      rd(SCTRP_SEL_BASE);
      wr(SCTRP_SEL_BASE, 8'h05);
      roValue = 8'h00;
      rd(SCTRP_SEL_BASE);
   endtask

   task automatic t_alias();
      sctrp_sel_t sels [4];
      sels = '{SCTRP_SEL_BASE, SCTRP_SEL_OUTPUT_BIT_SET,
               SCTRP_SEL_BIT_CLEAR_ALIAS, SCTRP_SEL_BIT_TOGGLE_ALIAS};
      wr(SCTRP_SEL_BASE, 8'h0A);
      wr(SCTRP_SEL_OUTPUT_BIT_SET, 8'h05);
      wr(SCTRP_SEL_BIT_CLEAR_ALIAS, 8'h06);
      wr(SCTRP_SEL_BIT_TOGGLE_ALIAS, 8'h23);
      foreach (sels[i])
         rd(sels[i]);
      // back to back: set then toggle with no idle cycle between
      access = '{1'b1, 1'b1, SCTRP_SEL_OUTPUT_BIT_SET, 8'h01};
      @(posedge clk);
      #1;
      access = '{1'b1, 1'b1, SCTRP_SEL_BIT_TOGGLE_ALIAS, 8'h03};
      @(posedge clk);
      #1;
      access = '0;
      model = (model | 8'h01) ^ 8'h03;
      @(posedge clk);
      #1;
      check(value & WM, model);
      rd(SCTRP_SEL_BIT_CLEAR_ALIAS);
   endtask

   // soft reset outranks a write in the same cycle on i_dut; i_dut_dbg keeps the write and ignores the soft reset
   task automatic t_soft();
      wr(SCTRP_SEL_BASE, 8'h2C);
      softRst = 1'b1;
      access = '{1'b1, 1'b1, SCTRP_SEL_OUTPUT_BIT_SET, 8'h03};
      @(posedge clk);
      #1;
      access = '0;
      softRst = 1'b0;
      model = SCTRP_RST_VAL & WM;
      @(posedge clk);
      #1;
      check(value & WM, model);
      check(valueDbg & WM, 8'h2F);
      rd(SCTRP_SEL_BASE);
      softRst = 1'b1;
      @(posedge clk);
      #1;
      softRst = 1'b0;
      @(posedge clk);
      #1;
      check(valueDbg & WM, 8'h2F);
      check(value & WM, model);
   endtask

   task automatic closeOut();
      if (badCount == 0 && totalChecks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_access();
      t_alias();
      t_soft();
      closeOut();
   end
endmodule
